// ### rtl/fifo_mem.sv
// fifo storage array with registered, write-through read data
module fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  // ==================================================================
  // storage
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // write-through so a word pushed into an empty fifo is readable next cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (wr_en_i && wr_addr_i == rd_addr_i) begin
      rd_data_o <= wr_data_i;
    end else begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule // fifo_mem

// ### rtl/i2c_irq_pkg.sv
// shared constants and types of the raw interrupt status block
package i2c_irq_pkg;

  // ==================================================================
  // register offsets
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA      = 8'h10;
  localparam logic [7:0] OFF_MASKED    = 8'h2c;
  localparam logic [7:0] OFF_INT_EN    = 8'h30;
  localparam logic [7:0] OFF_RAW       = 8'h34;
  localparam logic [7:0] OFF_RX_TL     = 8'h38;
  localparam logic [7:0] OFF_TX_TL     = 8'h3c;
  localparam logic [7:0] OFF_RDREQ_CLR = 8'h50;
  localparam logic [7:0] OFF_ABORT_CLR = 8'h54;
  localparam logic [7:0] OFF_ENABLE    = 8'h6c;
  localparam logic [7:0] OFF_ABORT_SRC = 8'h80;

  // ==================================================================
  // field positions and widths
  localparam int EN_BIT      = 0;
  localparam int TXE_SEL_BIT = 0;
  localparam int BYTE_W      = 8;
  localparam int CMD_W       = 9;
  localparam int DEPTH       = 16;
  localparam int PTR_W       = 4;
  localparam int CNT_W       = 5;
  localparam int TL_W        = 4;
  localparam int REASON_W    = 8;
  localparam int INT_EN_W    = 12;
  localparam int FLAG_W      = 7;

  localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;

  // ==================================================================
  // reset values
  localparam logic [INT_EN_W-1:0] INT_EN_RST = 12'h8ff;
  localparam logic [FLAG_W-1:0]   RAW_RST    = 7'h00;
  localparam logic [TL_W-1:0]     TL_RST     = 4'h0;

  // ==================================================================
  // carriers; flags_t bit 0 is the receive under-run flag
  typedef struct packed {
    logic transfer_abort_flag;
    logic read_request_flag;
    logic tx_threshold_flag;
    logic tx_overflow_flag;
    logic rx_threshold_flag;
    logic rx_overrun_flag;
    logic rx_underrun_flag;
  } flags_t;

  typedef struct packed {
    flags_t                raw;
    logic                  controller_enable;
    logic                  tx_empty_control_select;
    logic [INT_EN_W-1:0]   int_en;
    logic [TL_W-1:0]       rx_threshold_level;
    logic [TL_W-1:0]       tx_threshold_level;
    logic [CNT_W-1:0]      rx_cnt;
    logic [CNT_W-1:0]      tx_cnt;
    logic [PTR_W-1:0]      rx_wp;
    logic [PTR_W-1:0]      rx_rp;
    logic [PTR_W-1:0]      tx_wp;
    logic [PTR_W-1:0]      tx_rp;
    logic                  blocked;
    logic [REASON_W-1:0]   reason;
    logic                  hold;
    logic                  off_busy;
    logic                  off_tgl;
    logic [CMD_W-1:0]      off_data;
    logic                  act_s1;
    logic                  act_s2;
    logic                  done_s1;
    logic                  done_s2;
    logic                  ack_s1;
    logic                  ack_s2;
    logic                  ack_q;
    logic                  rx_s1;
    logic                  rx_s2;
    logic                  rx_q;
    logic                  rd_s1;
    logic                  rd_s2;
    logic                  rd_q;
    logic                  ab_s1;
    logic                  ab_s2;
    logic                  ab_q;
    logic [31:0]           rdata;
  } core_t;

  typedef struct packed {
    logic                  off_s1;
    logic                  off_s2;
    logic                  off_q;
    logic                  ready;
    logic                  ack_tgl;
    logic [CMD_W-1:0]      data;
    logic                  rx_tgl;
    logic [BYTE_W-1:0]     rx_data;
    logic                  rd_tgl;
    logic                  ab_tgl;
    logic [REASON_W-1:0]   ab_reason;
    logic                  hold_s1;
    logic                  hold_s2;
  } link_t;

endpackage

// ### rtl/i2c_raw_interrupt_status.sv
// raw interrupt status flags, fifo bookkeeping and link crossing
module i2c_raw_interrupt_status
  import i2c_irq_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                link_clk_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  output logic      [31:0]         reg_rdata_o,
  input  wire logic                link_busy_i,
  input  wire logic                link_shift_done_i,
  input  wire logic                link_rx_valid_i,
  input  wire logic [BYTE_W-1:0]   link_rx_data_i,
  input  wire logic                link_rd_req_i,
  input  wire logic                link_abort_i,
  input  wire logic [REASON_W-1:0] link_abort_reason_i,
  input  wire logic                link_tx_take_i,
  output logic                     link_tx_ready_o,
  output logic      [CMD_W-1:0]    link_tx_data_o,
  output logic                     link_scl_hold_o
);

  // ==================================================================
  // state and decode
  core_t                c_reg;
  core_t                c_next;
  link_t                l_reg;
  link_t                l_next;
  logic [BYTE_W-1:0]    rx_rd_data;
  logic [CMD_W-1:0]     tx_rd_data;
  logic                 rx_ev;
  logic                 rd_ev;
  logic                 ab_ev;
  logic                 ack_ev;
  logic                 en_ind;
  logic                 data_rd;
  logic                 data_wr;
  logic                 rdreq_clr_rd;
  logic                 abort_clr_rd;
  logic                 rx_full;
  logic                 tx_full;
  logic                 rx_push;
  logic                 rx_pop;
  logic                 tx_push;
  logic                 tx_pop;
  logic [FLAG_W-1:0]    masked;

  assign rx_ev        = c_reg.rx_s2 ^ c_reg.rx_q;
  assign rd_ev        = c_reg.rd_s2 ^ c_reg.rd_q;
  assign ab_ev        = c_reg.ab_s2 ^ c_reg.ab_q;
  assign ack_ev       = c_reg.ack_s2 ^ c_reg.ack_q;
  // the controller counts as enabled until its machines are idle
  assign en_ind       = c_reg.controller_enable | c_reg.act_s2;
  assign data_rd      = reg_rd_i && reg_addr_i == OFF_DATA;
  assign data_wr      = reg_wr_i && reg_addr_i == OFF_DATA;
  assign rdreq_clr_rd = reg_rd_i && reg_addr_i == OFF_RDREQ_CLR;
  assign abort_clr_rd = reg_rd_i && reg_addr_i == OFF_ABORT_CLR;
  assign rx_full      = c_reg.rx_cnt == FIFO_FULL;
  assign tx_full      = c_reg.tx_cnt == FIFO_FULL;
  assign rx_push      = rx_ev && c_reg.controller_enable && !rx_full;
  assign rx_pop       = data_rd && c_reg.rx_cnt != '0;
  assign tx_push      = data_wr && c_reg.controller_enable && !c_reg.blocked && !tx_full;
  assign tx_pop       = !c_reg.off_busy && c_reg.tx_cnt != '0 && c_reg.controller_enable
                        && !c_reg.blocked;
  assign masked       = c_reg.raw & c_reg.int_en[FLAG_W-1:0];

  // ==================================================================
  // fifo storage
  fifo_mem #(.WIDTH(BYTE_W), .DEPTH(DEPTH), .AW(PTR_W)) u_rx_mem (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (rx_push),
    .wr_addr_i (c_reg.rx_wp),
    .wr_data_i (l_reg.rx_data),
    .rd_addr_i (c_reg.rx_rp),
    .rd_data_o (rx_rd_data)
  );

  fifo_mem #(.WIDTH(CMD_W), .DEPTH(DEPTH), .AW(PTR_W)) u_tx_mem (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (tx_push),
    .wr_addr_i (c_reg.tx_wp),
    .wr_data_i (reg_wdata_i[CMD_W-1:0]),
    .rd_addr_i (c_reg.tx_rp),
    .rd_data_o (tx_rd_data)
  );

  // ==================================================================
  // controller clock domain
  always_comb begin
    c_next = c_reg;
    // only the second stage of each synchroniser feeds logic
    c_next.act_s1  = link_busy_i;
    c_next.act_s2  = c_reg.act_s1;
    c_next.done_s1 = link_shift_done_i;
    c_next.done_s2 = c_reg.done_s1;
    c_next.ack_s1  = l_reg.ack_tgl;
    c_next.ack_s2  = c_reg.ack_s1;
    c_next.ack_q   = c_reg.ack_s2;
    c_next.rx_s1   = l_reg.rx_tgl;
    c_next.rx_s2   = c_reg.rx_s1;
    c_next.rx_q    = c_reg.rx_s2;
    c_next.rd_s1   = l_reg.rd_tgl;
    c_next.rd_s2   = c_reg.rd_s1;
    c_next.rd_q    = c_reg.rd_s2;
    c_next.ab_s1   = l_reg.ab_tgl;
    c_next.ab_s2   = c_reg.ab_s1;
    c_next.ab_q    = c_reg.ab_s2;

    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_MAIN_CTRL: c_next.tx_empty_control_select = reg_wdata_i[TXE_SEL_BIT];
        OFF_ENABLE:    c_next.controller_enable       = reg_wdata_i[EN_BIT];
        OFF_INT_EN:    c_next.int_en                  = reg_wdata_i[INT_EN_W-1:0];
        OFF_RX_TL:     c_next.rx_threshold_level      = reg_wdata_i[TL_W-1:0];
        OFF_TX_TL:     c_next.tx_threshold_level      = reg_wdata_i[TL_W-1:0];
        default:       c_next.rdata                   = c_reg.rdata;
      endcase
    end

    // receive fifo; a byte arriving when full is acked by the link and lost
    c_next.rx_cnt = c_reg.rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);
    if (rx_push) begin
      c_next.rx_wp = c_reg.rx_wp + 4'h1;
    end
    if (rx_pop) begin
      c_next.rx_rp = c_reg.rx_rp + 4'h1;
    end
    if (!c_next.controller_enable) begin
      c_next.rx_cnt = '0;
      c_next.rx_wp  = '0;
      c_next.rx_rp  = '0;
    end

    // transmit fifo and the one-word offer to the link
    c_next.tx_cnt = c_reg.tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
    if (tx_push) begin
      c_next.tx_wp = c_reg.tx_wp + 4'h1;
    end
    if (ack_ev) begin
      c_next.off_busy = 1'b0;
    end
    if (tx_pop) begin
      c_next.tx_rp    = c_reg.tx_rp + 4'h1;
      c_next.off_busy = 1'b1;
      c_next.off_tgl  = ~c_reg.off_tgl;
      c_next.off_data = tx_rd_data;
    end
    if (abort_clr_rd) begin
      c_next.blocked = 1'b0;
    end
    if (ab_ev) begin
      c_next.blocked = 1'b1;
    end
    // a word already offered to the link is not recalled by a flush
    if (!c_next.controller_enable || ab_ev || c_reg.blocked) begin
      c_next.tx_cnt = '0;
      c_next.tx_wp  = '0;
      c_next.tx_rp  = '0;
    end

    // error flags: cleared by the enable indication, held while active
    if (!en_ind) begin
      c_next.raw.rx_underrun_flag = 1'b0;
      c_next.raw.rx_overrun_flag  = 1'b0;
      c_next.raw.tx_overflow_flag = 1'b0;
    end
    if (data_rd && c_reg.rx_cnt == '0 && en_ind) begin
      c_next.raw.rx_underrun_flag = 1'b1;
    end
    if (rx_ev && rx_full && c_reg.controller_enable) begin
      c_next.raw.rx_overrun_flag = 1'b1;
    end
    if (data_wr && tx_full && c_reg.controller_enable && !c_reg.blocked) begin
      c_next.raw.tx_overflow_flag = 1'b1;
    end

    // level flags follow occupancy with one cycle of lag while the controller is enabled
    c_next.raw.rx_threshold_flag = c_next.controller_enable
      && c_reg.rx_cnt >= {1'b0, c_reg.rx_threshold_level};
    if (c_reg.controller_enable) begin
      c_next.raw.tx_threshold_flag = c_reg.tx_cnt <= {1'b0, c_reg.tx_threshold_level}
        && (!c_reg.tx_empty_control_select || c_reg.done_s2);
    end else begin
      c_next.raw.tx_threshold_flag = c_reg.act_s2;
    end

    // slave read request and clock stretch
    if (rdreq_clr_rd) begin
      c_next.raw.read_request_flag = 1'b0;
    end
    if (data_wr || !c_reg.controller_enable) begin
      c_next.hold = 1'b0;
    end
    if (rd_ev && c_reg.controller_enable) begin
      c_next.raw.read_request_flag = 1'b1;
      c_next.hold                  = 1'b1;
    end

    // transfer abort and its reason
    if (abort_clr_rd) begin
      c_next.raw.transfer_abort_flag = 1'b0;
      c_next.reason                  = '0;
    end
    if (ab_ev) begin
      c_next.raw.transfer_abort_flag = 1'b1;
      c_next.reason = c_next.reason | l_reg.ab_reason;
    end

    // read data; unmapped offsets answer zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_MAIN_CTRL: c_next.rdata = 32'(c_reg.tx_empty_control_select);
        OFF_ENABLE:    c_next.rdata = 32'(c_reg.controller_enable);
        OFF_DATA:      c_next.rdata = rx_pop ? 32'(rx_rd_data) : 32'h0000_0000;
        OFF_MASKED:    c_next.rdata = 32'(masked);
        OFF_INT_EN:    c_next.rdata = 32'(c_reg.int_en);
        OFF_RAW:       c_next.rdata = 32'(c_reg.raw);
        OFF_RX_TL:     c_next.rdata = 32'(c_reg.rx_threshold_level);
        OFF_TX_TL:     c_next.rdata = 32'(c_reg.tx_threshold_level);
        OFF_RDREQ_CLR: c_next.rdata = 32'(c_reg.raw.read_request_flag);
        OFF_ABORT_CLR: c_next.rdata = 32'(c_reg.raw.transfer_abort_flag);
        OFF_ABORT_SRC: c_next.rdata = 32'(c_reg.reason);
        default:       c_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_reg                    <= '0;
      c_reg.raw                <= RAW_RST;
      c_reg.int_en             <= INT_EN_RST;
      c_reg.rx_threshold_level <= TL_RST;
      c_reg.tx_threshold_level <= TL_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  // ==================================================================
  // link clock domain; events cross as toggles, words stay still meanwhile
  always_comb begin
    l_next = l_reg;
    l_next.off_s1  = c_reg.off_tgl;
    l_next.off_s2  = l_reg.off_s1;
    l_next.off_q   = l_reg.off_s2;
    l_next.hold_s1 = c_reg.hold;
    l_next.hold_s2 = l_reg.hold_s1;
    if (l_reg.off_s2 != l_reg.off_q) begin
      l_next.ready = 1'b1;
      l_next.data  = c_reg.off_data;
    end
    if (link_tx_take_i && l_reg.ready) begin
      l_next.ready   = 1'b0;
      l_next.ack_tgl = ~l_reg.ack_tgl;
    end
    if (link_rx_valid_i) begin
      l_next.rx_tgl  = ~l_reg.rx_tgl;
      l_next.rx_data = link_rx_data_i;
    end
    if (link_rd_req_i) begin
      l_next.rd_tgl = ~l_reg.rd_tgl;
    end
    if (link_abort_i) begin
      l_next.ab_tgl    = ~l_reg.ab_tgl;
      l_next.ab_reason = link_abort_reason_i;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign reg_rdata_o     = c_reg.rdata;
  assign link_tx_ready_o = l_reg.ready;
  assign link_tx_data_o  = l_reg.data;
  assign link_scl_hold_o = l_reg.hold_s2;

  // ==================================================================
  // checks
  sequence s_abort_ev;
    ab_ev;
  endsequence

  sequence s_tx_flushed;
    c_reg.blocked && c_reg.tx_cnt == '0 && c_reg.raw.transfer_abort_flag;
  endsequence

  property p_underrun;
    @(posedge clk_i) disable iff (!rst_n_i)
      data_rd && c_reg.rx_cnt == '0 && en_ind |=> c_reg.raw.rx_underrun_flag;
  endproperty
  a_underrun: assert property (p_underrun) else $error("under-run not flagged");

  property p_idle_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      !en_ind |=> !(c_reg.raw.rx_underrun_flag || c_reg.raw.rx_overrun_flag
                    || c_reg.raw.tx_overflow_flag);
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("error flag kept");

  property p_overrun;
    @(posedge clk_i) disable iff (!rst_n_i)
      rx_ev && rx_full && c_reg.controller_enable && !data_rd
      |=> c_reg.raw.rx_overrun_flag && c_reg.rx_cnt == FIFO_FULL;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_rx_below;
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(c_reg.rx_cnt) < {1'b0, $past(c_reg.rx_threshold_level)}
      |-> !c_reg.raw.rx_threshold_flag;
  endproperty
  a_rx_below: assert property (p_rx_below) else $error("rx threshold stuck");

  property p_rx_flush;
    @(posedge clk_i) disable iff (!rst_n_i)
      $fell(c_reg.controller_enable)
      |-> c_reg.rx_cnt == '0 && !c_reg.raw.rx_threshold_flag;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx fifo not flushed");

  property p_tx_ovf;
    @(posedge clk_i) disable iff (!rst_n_i)
      data_wr && tx_full && c_reg.controller_enable && !c_reg.blocked
      |=> c_reg.raw.tx_overflow_flag && c_reg.tx_cnt <= $past(c_reg.tx_cnt);
  endproperty
  a_tx_ovf: assert property (p_tx_ovf) else $error("tx overflow missed");

  property p_tx_thr_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
      c_reg.controller_enable && c_reg.tx_empty_control_select && !c_reg.done_s2
      |=> !c_reg.raw.tx_threshold_flag;
  endproperty
  a_tx_thr_wait: assert property (p_tx_thr_wait) else $error("tx flag early");

  property p_tx_thr_above;
    @(posedge clk_i) disable iff (!rst_n_i)
      c_reg.controller_enable && c_reg.tx_cnt > {1'b0, c_reg.tx_threshold_level}
      |=> !c_reg.raw.tx_threshold_flag;
  endproperty
  a_tx_thr_above: assert property (p_tx_thr_above) else $error("tx flag high");

  property p_tx_disabled;
    @(posedge clk_i) disable iff (!rst_n_i)
      !c_reg.controller_enable |=> c_reg.raw.tx_threshold_flag == $past(c_reg.act_s2);
  endproperty
  a_tx_disabled: assert property (p_tx_disabled) else $error("tx flag off");

  sequence s_req_set;
    c_reg.raw.read_request_flag && c_reg.hold;
  endsequence

  // the flag may only drop after a read of the clear register
  property p_rdreq;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_ev && c_reg.controller_enable |=> s_req_set
      ##1 (c_reg.raw.read_request_flag || $past(rdreq_clr_rd));
  endproperty
  a_rdreq: assert property (p_rdreq) else $error("read request lost");

  property p_rdreq_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
      rdreq_clr_rd && !rd_ev |=> !c_reg.raw.read_request_flag;
  endproperty
  a_rdreq_clr: assert property (p_rdreq_clr) else $error("request not cleared");

  property p_abort;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_abort_ev |=> s_tx_flushed;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not handled");

  property p_unblock;
    @(posedge clk_i) disable iff (!rst_n_i)
      abort_clr_rd && !ab_ev |=> !c_reg.blocked && c_reg.reason == '0;
  endproperty
  a_unblock: assert property (p_unblock) else $error("fifo stays blocked");

  property p_masked;
    @(posedge clk_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i == OFF_MASKED |=> reg_rdata_o == 32'($past(masked));
  endproperty
  a_masked: assert property (p_masked) else $error("masked status wrong");

endmodule // i2c_raw_interrupt_status

// ### testbench/i2c_link_partner.sv
// link-side partner: remote bus party that sends events and takes commands
module i2c_link_partner
  import i2c_irq_pkg::*;
(
  input  wire logic                link_clk_i,
  input  wire logic                tx_ready_i,
  input  wire logic [CMD_W-1:0]    tx_data_i,
  output logic                     rx_valid_o,
  output logic      [BYTE_W-1:0]   rx_data_o,
  output logic                     rd_req_o,
  output logic                     abort_o,
  output logic      [REASON_W-1:0] reason_o,
  output logic                     take_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic             stall = 1'b0;
  int               taken = 0;
  logic [CMD_W-1:0] last  = '0;

  initial {rx_valid_o, rd_req_o, abort_o, take_o, rx_data_o, reason_o} = '0;

  // ==================================================================
  // one-cycle event pulse; data lines invert once released
  task ev(input int k, input logic [7:0] d);
    @(posedge link_clk_i);
    rx_valid_o <= (k == 0);
    rd_req_o   <= (k == 1);
    abort_o    <= (k == 2);
    rx_data_o  <= d;
    reason_o   <= d;
    @(posedge link_clk_i);
    {rx_valid_o, rd_req_o, abort_o} <= 3'h0;
    rx_data_o <= ~d;
    reason_o  <= ~d;
    // spacing keeps same-kind events from merging
    repeat (3) @(posedge link_clk_i);
  endtask

  // ==================================================================
  // take each offered command unless stalled
  always @(posedge link_clk_i) begin
    take_o <= tx_ready_i && !stall && !take_o;
    if (take_o && tx_ready_i) begin
      taken <= taken + 1;
      last  <= tx_data_i;
    end
  end
endmodule // i2c_link_partner

// ### testbench/tb_i2c_raw_interrupt_status.sv
// self-checking bench for the raw interrupt status block
module tb_i2c_raw_interrupt_status
  import i2c_irq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        lclk  = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        busy  = 1'b0;
  logic        done  = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat, v;
  logic [7:0]  rxd, abr;
  logic [8:0]  txd;
  logic        rxv, rrq, ab, take, txr, hold;
  int          failures = 0;
  int          checked  = 0;
  int          n;

  always #5 clk_i = ~clk_i;
  always #7.5 lclk = ~lclk;

  i2c_raw_interrupt_status dut (.clk_i(clk_i), .rst_n_i(rst_n), .link_clk_i(lclk),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_rdata_o(rdat), .link_busy_i(busy), .link_shift_done_i(done),
    .link_rx_valid_i(rxv), .link_rx_data_i(rxd), .link_rd_req_i(rrq),
    .link_abort_i(ab), .link_abort_reason_i(abr), .link_tx_take_i(take),
    .link_tx_ready_o(txr), .link_tx_data_o(txd), .link_scl_hold_o(hold));

  i2c_link_partner u_p (.link_clk_i(lclk), .tx_ready_i(txr), .tx_data_i(txd),
    .rx_valid_o(rxv), .rx_data_o(rxd), .rd_req_o(rrq), .abort_o(ab),
    .reason_o(abr), .take_o(take));

  // ==================================================================
  // helpers
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task w(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr   <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // extra negedge samples the read data registered on the second edge
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdat;
  endtask
  task rb(input int b, input logic e, input string nm);
    rd_reg(OFF_RAW, v);
    chk(nm, e, v[b]);
  endtask

  // ==================================================================
  // scenarios
  task t_reset();
    rd_reg(OFF_RAW, v);
    chk("raw rst", 32'h0, v);
    wr_reg(OFF_RAW, 32'h7f);
    rd_reg(OFF_RAW, v);
    chk("raw ro", 32'h0, v);
    $display("test reset done");
  endtask
  task t_under();
    wr_reg(OFF_ENABLE, 32'h1);
    rd_reg(OFF_DATA, v);
    rb(0, 1'b1, "underrun");
    rd_reg(OFF_MASKED, v);
    chk("masked on", 1'b1, v[0]);
    wr_reg(OFF_INT_EN, 32'h0);
    rd_reg(OFF_MASKED, v);
    chk("masked off", 32'h0, v);
    wr_reg(OFF_INT_EN, 32'h8ff);
    $display("test underrun done");
  endtask
  task t_rx();
    wr_reg(OFF_RX_TL, 32'h2);
    u_p.ev(0, 8'h3c);
    w(20);
    rb(2, 1'b0, "rx below");
    u_p.ev(0, 8'h5a);
    w(20);
    rb(2, 1'b1, "rx at level");
    rd_reg(OFF_DATA, v);
    chk("rx byte", 8'h3c, v[7:0]);
    rb(2, 1'b0, "rx dropped");
    for (int i = 0; i < 15; i++)
      u_p.ev(0, 8'h10);
    w(20);
    rb(1, 1'b0, "rx full");
    u_p.ev(0, 8'hee);
    w(20);
    rb(1, 1'b1, "overrun");
    $display("test receive done");
  endtask
  task t_dis();
    w(1);
    busy <= 1'b1;
    w(9);
    wr_reg(OFF_ENABLE, 32'h0);
    w(10);
    rd_reg(OFF_RAW, v);
    chk("held", 7'h13, v[6:0]);
    w(1);
    busy <= 1'b0;
    w(9);
    rd_reg(OFF_RAW, v);
    chk("idle", 32'h0, v);
    wr_reg(OFF_ENABLE, 32'h1);
    w(3);
    rb(2, 1'b0, "rx flushed");
    $display("test disable done");
  endtask
  task t_tx();
    u_p.stall = 1'b1;
    for (int i = 1; i <= 16; i++)
      wr_reg(OFF_DATA, i);
    w(20);
    rb(4, 1'b0, "tx above");
    wr_reg(OFF_DATA, 32'h11);
    rb(3, 1'b0, "tx full");
    wr_reg(OFF_DATA, 32'h12);
    rb(3, 1'b1, "tx overflow");
    u_p.stall = 1'b0;
    w(600);
    chk("taken", 17, u_p.taken);
    chk("last", 32'h11, u_p.last);
    rb(4, 1'b1, "tx empty");
    wr_reg(OFF_MAIN_CTRL, 32'h1);
    w(10);
    rb(4, 1'b0, "tx shifting");
    done <= 1'b1;
    w(10);
    rb(4, 1'b1, "tx shifted");
    wr_reg(OFF_MAIN_CTRL, 32'h0);
    $display("test transmit done");
  endtask
  task t_req();
    u_p.ev(1, 8'h00);
    w(20);
    rb(5, 1'b1, "rd request");
    chk("scl hold", 1'b1, hold);
    wr_reg(OFF_DATA, 32'ha5);
    w(20);
    chk("scl free", 1'b0, hold);
    rd_reg(OFF_RDREQ_CLR, v);
    rb(5, 1'b0, "rd request clr");
    $display("test read request done");
  endtask
  task t_abort();
    n = u_p.taken;
    u_p.ev(2, 8'h05);
    w(20);
    rb(6, 1'b1, "abort");
    rd_reg(OFF_ABORT_SRC, v);
    chk("abort src", 32'h05, v);
    wr_reg(OFF_DATA, 32'h33);
    w(50);
    chk("blocked", n, u_p.taken);
    rd_reg(OFF_ABORT_CLR, v);
    wr_reg(OFF_DATA, 32'h44);
    w(50);
    chk("accepted", 32'h44, u_p.last);
    $display("test abort done");
  endtask

  // ==================================================================
  // sequence, watchdog and verdict
  task final_report();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    w(10);
    rst_n <= 1'b1;
    w(2);
    t_reset();
    t_under();
    t_rx();
    t_dis();
    t_tx();
    t_req();
    t_abort();
    final_report();
  end
  // tests need about 1.2k cycles
  initial begin
    #100us;
    failures++;
    final_report();
  end
endmodule // tb_i2c_raw_interrupt_status
